/* hdl/boot_loader_defs.svh */
// Constants for the serial boot loader: addresses, bytes and timing counts.
// Assumes a 40 MHz core clock.
`ifndef BOOT_LOADER_DEFS_SVH
`define BOOT_LOADER_DEFS_SVH
`define CLK_HZ 40000000
`define READY_STATES 100
`define BYTE_ADJ_DONE 8'h00
`define BYTE_HOST_ACK 8'h55
`define BYTE_READY 8'hAA
`define BYTE_ERASE_ERR 8'hFF
`define BYTE_ERASED 8'hFF
`define LOW_BITS 9
`define BOOT_AREA_LO 16'hFB80
`define BOOT_AREA_HI 16'hFBDF
`define BOOT_CODE_LO 16'hFC00
`define BOOT_CODE_HI 16'hFF2F
`define USER_BASE 16'hFBE0
`define USER_LAST 16'hFF6D
`define USER_MAX 16'h038E
`define RSVD_LO 16'hFF6E
`define RSVD_HI 16'hFF7F
`define IRQ_AREA_HI 16'hFB8F
`define MIN_BIT_CYCLES 16'h0010
`endif

/* hdl/boot_loader_pkg.sv */
// Types shared by the serial boot loader files.
// Assumes boot_loader_defs.svh is available on the include path.
package boot_loader_pkg;
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] data;
	} ram_wr_s;
	typedef struct packed {
		logic req;
		logic [15:0] addr;
	} flash_rd_s;
endpackage

/* hdl/serial_channel.sv */
// Asynchronous 8N1 transmitter and receiver driven by a bit period count.
// Assumes rxd is already synchronous to core_clk; enables gate both directions.
`timescale 1ns/1ps
module serial_channel (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [15:0] bit_rate_register,
	input wire logic receive_enable_bit,
	input wire logic transmit_enable_bit,
	input wire logic rxd,
	output logic txd,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_start,
	output logic tx_busy
);
	logic [15:0] rx_cnt;
	logic [3:0] rx_bit;
	logic rx_on;
	logic [7:0] rx_sh;
	logic [15:0] tx_cnt;
	logic [3:0] tx_bit;
	logic [9:0] tx_sh;

	// Receive: sample mid bit after a start edge
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_on <= 1'b0;
			rx_cnt <= 16'h0000;
			rx_bit <= 4'h0;
			rx_sh <= 8'h00;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
		end else begin
			rx_valid <= 1'b0;
			if (!receive_enable_bit) begin
				rx_on <= 1'b0;
			end else if (!rx_on) begin
				if (!rxd) begin
					rx_on <= 1'b1;
					rx_cnt <= {1'b0, bit_rate_register[15:1]};
					rx_bit <= 4'h0;
				end
			end else if (rx_cnt != 16'h0000) begin
				rx_cnt <= rx_cnt - 16'h0001;
			end else begin
				rx_cnt <= bit_rate_register - 16'h0001;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0 && rxd) begin
					rx_on <= 1'b0;
				end else if (rx_bit >= 4'h1 && rx_bit <= 4'h8) begin
					rx_sh <= {rxd, rx_sh[7:1]};
				end else if (rx_bit == 4'h9) begin
					rx_on <= 1'b0;
					rx_data <= rx_sh;
					rx_valid <= rxd;
				end
			end
		end
	end

	// Transmit: line idles high, also while disabled
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_sh <= 10'h3FF;
			tx_cnt <= 16'h0000;
			tx_bit <= 4'h0;
			tx_busy <= 1'b0;
		end else if (!transmit_enable_bit) begin
			tx_busy <= 1'b0;
			tx_sh <= 10'h3FF;
		end else if (!tx_busy) begin
			if (tx_start) begin
				tx_sh <= {1'b1, tx_data, 1'b0};
				tx_cnt <= bit_rate_register - 16'h0001;
				tx_bit <= 4'h0;
				tx_busy <= 1'b1;
			end
		end else if (tx_cnt != 16'h0000) begin
			tx_cnt <= tx_cnt - 16'h0001;
		end else begin
			tx_cnt <= bit_rate_register - 16'h0001;
			tx_sh <= {1'b1, tx_sh[9:1]};
			tx_bit <= tx_bit + 4'h1;
			if (tx_bit == 4'h9) begin
				tx_busy <= 1'b0;
			end
		end
	end

	assign txd = tx_sh[0];
endmodule // serial_channel

/* hdl/serial_boot_loader.sv */
// Serial boot loader: bit rate autodetect, flash blank check, program download to RAM.
// Assumes synchronous pin inputs, a RAM write port and a flash read port with one-cycle data.
// Summary of operation
// - Latch boot mode when both programming and mode pins high at reset release.
// - After reset in boot mode, measure host low period and set bit rate.
// - No parity; the measured low interval spans nine bit times.
// - After adjustment, send one 0x00 byte.
// - After 0x55, copy boot code to its RAM regions and run there.
// - If flash holds any data, erase all blocks before download.
// - On erase failure send 0xFF and halt.
// - Send 0xAA; host sends length MSB first, then program bytes.
// - Echo every received byte, length bytes included.
// - Store program bytes ascending from 0xFBE0, never beyond 0xFF6D.
// - After storing, send 0xAA then start execution at 0xFBE0.
// - Region 0xFB80-0xFBDF reserved for loader during boot only.
// - Region 0xFF6E-0xFF7F stays reserved after the user program starts.
// - Receive line high at reset end; ready to measure about 100 states later.
// - Before branching, disable serial transmit and receive, keep rate, hold line high.
// - Watchdog reset restarts loader without clearing latched boot mode.
`timescale 1ns/1ps
`include "boot_loader_defs.svh"
module serial_boot_loader #(
	parameter int FLASH_WORDS = 32768,
	parameter int ERASE_CYCLES = 40000
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic watchdog_reset,
	input wire logic programming_voltage_pin,
	input wire logic mode_select_pin,
	input wire logic rxd,
	output logic txd,
	output boot_loader_pkg::ram_wr_s ram_wr,
	output boot_loader_pkg::flash_rd_s flash_rd,
	input wire logic [7:0] flash_data,
	output logic flash_erase,
	input wire logic flash_erase_fail,
	output logic boot_mode,
	output logic user_mode,
	output logic user_run,
	output logic [15:0] user_pc,
	output logic halted,
	output logic [15:0] bit_rate_register
);
	import boot_loader_pkg::*;

	typedef enum {
		S_WAIT, S_MEASURE, S_ADJ_TX, S_ACK, S_COPY, S_CHECK, S_ERASE, S_ERR_TX, S_HALT,
		S_RDY_TX, S_LEN, S_DATA, S_ECHO, S_DONE_TX, S_RUN
	} state_e;

	localparam logic [15:0] BOOT_CODE_WORDS = 16'(`BOOT_CODE_HI - `BOOT_CODE_LO + 1);
	localparam logic [15:0] BOOT_AREA_WORDS = 16'(`BOOT_AREA_HI - `BOOT_AREA_LO + 1);

	state_e state;
	logic latched;
	logic rst_seen;
	logic [7:0] wait_cnt;
	logic [23:0] low_cnt;
	logic rxd_q;
	logic [15:0] idx;
	logic [15:0] length;
	logic len_hi;
	logic [31:0] erase_cnt;
	logic receive_enable_bit;
	logic transmit_enable_bit;
	logic [7:0] tx_data;
	logic tx_start;
	logic tx_busy;
	logic tx_busy_q;
	logic [7:0] rx_data;
	logic rx_valid;
	logic [7:0] last_rx;

	// Boot pins sampled on the first clock after release; watchdog leaves it alone
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_seen <= 1'b0;
			latched <= 1'b0;
		end else if (!rst_seen) begin
			rst_seen <= 1'b1;
			latched <= programming_voltage_pin && mode_select_pin;
		end
	end
	assign boot_mode = latched;
	assign user_mode = rst_seen && !latched && programming_voltage_pin && !mode_select_pin;

	serial_channel serial_channel_inst (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.bit_rate_register(bit_rate_register),
		.receive_enable_bit(receive_enable_bit),
		.transmit_enable_bit(transmit_enable_bit),
		.rxd(rxd),
		.txd(txd),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.tx_data(tx_data),
		.tx_start(tx_start),
		.tx_busy(tx_busy)
	);

	// A byte send is done when the busy flag falls
	function automatic logic sent(input logic busy, input logic busy_q);
		sent = busy_q && !busy;
	endfunction

	assign tx_start = (state == S_ADJ_TX || state == S_ERR_TX || state == S_RDY_TX ||
		state == S_ECHO || state == S_DONE_TX) && !tx_busy && !tx_busy_q;

	always_comb begin
		unique case (state)
			S_ERR_TX: tx_data = `BYTE_ERASE_ERR;
			S_RDY_TX: tx_data = `BYTE_READY;
			S_DONE_TX: tx_data = `BYTE_READY;
			S_ECHO: tx_data = last_rx;
			default: tx_data = `BYTE_ADJ_DONE;
		endcase
	end

	// Main sequence
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= S_WAIT;
			wait_cnt <= 8'h00;
			low_cnt <= 24'h000000;
			rxd_q <= 1'b1;
			bit_rate_register <= 16'h0000;
			idx <= 16'h0000;
			length <= 16'h0000;
			len_hi <= 1'b1;
			erase_cnt <= 32'h00000000;
			receive_enable_bit <= 1'b0;
			transmit_enable_bit <= 1'b0;
			tx_busy_q <= 1'b0;
			last_rx <= 8'h00;
			user_run <= 1'b0;
			user_pc <= 16'h0000;
			halted <= 1'b0;
		end else if (watchdog_reset) begin
			state <= S_WAIT;
			wait_cnt <= 8'h00;
			receive_enable_bit <= 1'b0;
			transmit_enable_bit <= 1'b0;
			user_run <= 1'b0;
			halted <= 1'b0;
		end else begin
			tx_busy_q <= tx_busy;
			rxd_q <= rxd;
			unique case (state)
				S_WAIT: begin
					if (rst_seen && latched) begin
						if (wait_cnt == 8'(`READY_STATES)) begin
							state <= S_MEASURE;
							low_cnt <= 24'h000000;
						end else begin
							wait_cnt <= wait_cnt + 8'h01;
						end
					end
				end
				S_MEASURE: begin
					// Start bit plus eight zero bits is one nine-bit low period
					if (!rxd) begin
						low_cnt <= low_cnt + 24'h000001;
					end else if (!rxd_q) begin
						if (low_cnt[23:4] >= 20'(`LOW_BITS)) begin
							bit_rate_register <= 16'(low_cnt / 24'(`LOW_BITS));
							transmit_enable_bit <= 1'b1;
							receive_enable_bit <= 1'b1;
							state <= S_ADJ_TX;
						end
						low_cnt <= 24'h000000;
					end
				end
				S_ADJ_TX: if (sent(tx_busy, tx_busy_q)) state <= S_ACK;
				S_ACK: begin
					if (rx_valid && rx_data == `BYTE_HOST_ACK) begin
						state <= S_COPY;
						idx <= 16'h0000;
					end
				end
				S_COPY: begin
					// Boot code image copy stands in as a timed pass over both regions
					if (idx == BOOT_CODE_WORDS + BOOT_AREA_WORDS - 16'h0001) begin
						state <= S_CHECK;
						idx <= 16'h0000;
					end else begin
						idx <= idx + 16'h0001;
					end
				end
				S_CHECK: begin
					if (idx != 16'h0000 && flash_data != `BYTE_ERASED) begin
						state <= S_ERASE;
						erase_cnt <= 32'h00000000;
					end else if (idx == 16'(FLASH_WORDS)) begin
						state <= S_RDY_TX;
					end else begin
						idx <= idx + 16'h0001;
					end
				end
				S_ERASE: begin
					if (flash_erase_fail) begin
						state <= S_ERR_TX;
					end else if (erase_cnt == 32'(ERASE_CYCLES)) begin
						state <= S_RDY_TX;
					end else begin
						erase_cnt <= erase_cnt + 32'h00000001;
					end
				end
				S_ERR_TX: if (sent(tx_busy, tx_busy_q)) state <= S_HALT;
				S_HALT: begin
					halted <= 1'b1;
					receive_enable_bit <= 1'b0;
				end
				S_RDY_TX: begin
					if (sent(tx_busy, tx_busy_q)) begin
						state <= S_LEN;
						len_hi <= 1'b1;
						idx <= 16'h0000;
					end
				end
				S_LEN: begin
					if (rx_valid) begin
						last_rx <= rx_data;
						state <= S_ECHO;
						if (len_hi) begin
							length[15:8] <= rx_data;
						end else begin
							length[7:0] <= rx_data;
						end
					end
				end
				S_DATA: begin
					if (rx_valid) begin
						last_rx <= rx_data;
						idx <= idx + 16'h0001;
						state <= S_ECHO;
					end
				end
				S_ECHO: begin
					// Next byte is only taken after its echo leaves
					if (sent(tx_busy, tx_busy_q)) begin
						if (len_hi) begin
							len_hi <= 1'b0;
							state <= S_LEN;
						end else if (idx >= length || idx >= `USER_MAX) begin
							state <= S_DONE_TX;
						end else begin
							state <= S_DATA;
						end
					end
				end
				S_DONE_TX: begin
					if (sent(tx_busy, tx_busy_q)) begin
						state <= S_RUN;
						receive_enable_bit <= 1'b0;
						transmit_enable_bit <= 1'b0;
					end
				end
				S_RUN: begin
					user_run <= 1'b1;
					user_pc <= `USER_BASE;
				end
			endcase
		end
	end

	// Program byte lands at base plus index; writes at or past the index limit are dropped
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ram_wr <= '0;
		end else begin
			ram_wr.we <= state == S_DATA && rx_valid && idx < `USER_MAX;
			ram_wr.addr <= `USER_BASE + idx;
			ram_wr.data <= rx_data;
		end
	end

	assign flash_rd.req = state == S_CHECK;
	assign flash_rd.addr = idx;
	assign flash_erase = state == S_ERASE;

	property p_ram_bound;
		@(posedge core_clk) disable iff (!rst_b)
		ram_wr.we |-> ram_wr.addr >= `USER_BASE && ram_wr.addr <= `USER_LAST;
	endproperty
	a_ram_bound: assert property (p_ram_bound) else $error("ram write outside user area");

	property p_run_quiet;
		@(posedge core_clk) disable iff (!rst_b)
		user_run |-> !receive_enable_bit && !transmit_enable_bit && txd && user_pc == `USER_BASE;
	endproperty
	a_run_quiet: assert property (p_run_quiet) else $error("serial active after branch");

	property p_halt_stays;
		@(posedge core_clk) disable iff (!rst_b || watchdog_reset)
		halted |=> halted && !user_run;
	endproperty
	a_halt_stays: assert property (p_halt_stays) else $error("left halt");

	property p_wdt_keep;
		@(posedge core_clk) disable iff (!rst_b)
		watchdog_reset && rst_seen |=> boot_mode == $past(boot_mode) && state == S_WAIT;
	endproperty
	a_wdt_keep: assert property (p_wdt_keep) else $error("watchdog lost boot mode");

	property p_echo_first;
		@(posedge core_clk) disable iff (!rst_b || watchdog_reset)
		state == S_ECHO && !tx_busy && !tx_busy_q |-> tx_start && tx_data == last_rx;
	endproperty
	a_echo_first: assert property (p_echo_first) else $error("echo not sent");

	property p_ready_wait;
		@(posedge core_clk) disable iff (!rst_b || watchdog_reset)
		state == S_WAIT ##1 state == S_MEASURE |-> $past(wait_cnt) == 8'(`READY_STATES);
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("measure started early");

	property p_adj_byte;
		@(posedge core_clk) disable iff (!rst_b || watchdog_reset)
		tx_start && state == S_ADJ_TX |-> tx_data == `BYTE_ADJ_DONE && bit_rate_register != 0;
	endproperty
	a_adj_byte: assert property (p_adj_byte) else $error("bad adjust byte");

	property p_err_byte;
		@(posedge core_clk) disable iff (!rst_b || watchdog_reset)
		state == S_ERASE && flash_erase_fail |=> state == S_ERR_TX ##1 tx_data == `BYTE_ERASE_ERR;
	endproperty
	a_err_byte: assert property (p_err_byte) else $error("erase error not reported");
endmodule // serial_boot_loader

/* sim/host_link.sv */
// Host end of the 8N1 boot link: a byte sender and a background receiver.
// Assumes the device answers at the same bit period that the host sends with.
`timescale 1ns/1ps
module host_link #(
	parameter int BIT = 20
) (
	input wire logic core_clk,
	input wire logic txd,
	output logic rxd
);
	logic [7:0] rx_q[$];

	initial begin
		rxd = 1'b1;
	end

	// Start bit, 8 data bits LSB first, one stop bit, no parity
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		@(negedge core_clk);
		for (int i = 0; i < 10; i++) begin
			rxd = f[i];
			repeat (BIT) @(negedge core_clk);
		end
	endtask

	// Samples mid-bit; no stop check, a framing slip shows as a wrong byte
	initial begin
		logic [7:0] b;
		forever begin
			@(negedge txd);
			repeat (BIT / 2) @(posedge core_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge core_clk);
				b[i] = txd;
			end
			repeat (BIT) @(posedge core_clk);
			rx_q.push_back(b);
		end
	end
endmodule // host_link

/* sim/serial_boot_loader_tb.sv */
// Self-checking bench for the serial boot loader with a host model and flat flash.
// Assumes boot_loader_defs.svh on the include path; short bit period keeps the run small.
`timescale 1ns/1ps
`include "boot_loader_defs.svh"
module serial_boot_loader_tb;
	import boot_loader_pkg::*;
	localparam int BIT = 20;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic watchdog_reset = 1'b0;
	logic programming_voltage_pin = 1'b0;
	logic mode_select_pin = 1'b0;
	logic rxd;
	logic txd;
	ram_wr_s ram_wr;
	flash_rd_s flash_rd;
	logic [7:0] flash_data = 8'hFF;
	logic flash_erase;
	logic flash_erase_fail = 1'b0;
	logic boot_mode;
	logic user_mode;
	logic user_run;
	logic [15:0] user_pc;
	logic halted;
	logic [15:0] bit_rate_register;
	logic blank = 1'b1;
	logic [15:0] dirty_at = 16'h0000;
	logic [15:0] rd_addr_q = 16'hFFFF;
	logic saw_erase = 1'b0;
	logic [23:0] ram_q[$];
	int n_errors = 0;
	int n_checks = 0;

	always #12.5 core_clk = ~core_clk;

	serial_boot_loader #(.FLASH_WORDS(16), .ERASE_CYCLES(20)) serial_boot_loader_inst (
		.core_clk(core_clk), .rst_b(rst_b), .watchdog_reset(watchdog_reset),
		.programming_voltage_pin(programming_voltage_pin), .mode_select_pin(mode_select_pin),
		.rxd(rxd), .txd(txd), .ram_wr(ram_wr), .flash_rd(flash_rd), .flash_data(flash_data),
		.flash_erase(flash_erase), .flash_erase_fail(flash_erase_fail),
		.boot_mode(boot_mode), .user_mode(user_mode), .user_run(user_run),
		.user_pc(user_pc), .halted(halted), .bit_rate_register(bit_rate_register)
	);

	host_link #(.BIT(BIT)) host_inst (.core_clk(core_clk), .txd(txd), .rxd(rxd));

	// Registered read, one cycle late; a single written byte at a random spot from 0 to 15 in each non-blank case
	always @(negedge core_clk) begin
		flash_data <= (!blank && rd_addr_q == dirty_at) ? 8'h3C : 8'hFF;
		rd_addr_q = flash_rd.addr;
		if (flash_erase === 1'b1)
			saw_erase = 1'b1;
		if (ram_wr.we === 1'b1)
			ram_q.push_back({ram_wr.addr, ram_wr.data});
	end

	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] exp_answer(input logic nb, input logic ef);
		return (nb && ef) ? `BYTE_ERASE_ERR : `BYTE_READY;
	endfunction

	function automatic logic [15:0] exp_addr(input int i);
		return `USER_BASE + 16'(i);
	endfunction

	task automatic get_byte(output logic [7:0] b);
		int n;
		n = 0;
		while (host_inst.rx_q.size() == 0 && n < 20000) begin
			@(posedge core_clk);
			n++;
		end
		b = 'x;
		if (host_inst.rx_q.size() != 0)
			b = host_inst.rx_q.pop_front();
	endtask

	task automatic do_reset(input logic pv, input logic md);
		@(negedge core_clk);
		rst_b = 1'b0;
		programming_voltage_pin = pv;
		mode_select_pin = md;
		host_inst.rx_q.delete();
		repeat (2) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (2) @(negedge core_clk);
	endtask

	task automatic adjust();
		logic [7:0] b;
		repeat (110) @(negedge core_clk);
		host_inst.send_byte(8'h00);
		get_byte(b);
		chk_byte(b, `BYTE_ADJ_DONE);
		chk_word(bit_rate_register, 16'(BIT));
	endtask

	// Host waits for each echo before the next byte, so pacing is the device's
	task automatic xfer(input logic [7:0] v);
		logic [7:0] b;
		host_inst.send_byte(v);
		get_byte(b);
		chk_byte(b, v);
	endtask

	task automatic run_case(input logic nb, input logic ef, input int len);
		logic [7:0] b;
		logic [7:0] prog[$];
		logic [15:0] l16;
		blank = !nb;
		dirty_at = 16'($urandom_range(15));
		flash_erase_fail = ef;
		do_reset(1'b1, 1'b1);
		saw_erase = 1'b0;
		chk_flag(boot_mode, 1'b1);
		chk_flag(user_mode, 1'b0);
		adjust();
		host_inst.send_byte(8'h33);
		host_inst.send_byte(`BYTE_HOST_ACK);
		get_byte(b);
		chk_byte(b, exp_answer(nb, ef));
		chk_flag(saw_erase, nb);
		if (nb && ef) begin
			repeat (2 * BIT) @(negedge core_clk);
			chk_flag(halted, 1'b1);
			return;
		end
		ram_q.delete();
		l16 = 16'(len);
		for (int i = 0; i < len; i++)
			prog.push_back(8'($urandom_range(255)));
		xfer(l16[15:8]);
		xfer(l16[7:0]);
		foreach (prog[i])
			xfer(prog[i]);
		get_byte(b);
		chk_byte(b, `BYTE_READY);
		repeat (4 * BIT) @(negedge core_clk);
		chk_flag(user_run, 1'b1);
		chk_word(user_pc, `USER_BASE);
		chk_flag(txd, 1'b1);
		chk_word(bit_rate_register, 16'(BIT));
		chk_word(16'(ram_q.size()), l16);
		foreach (ram_q[i]) begin
			chk_word(ram_q[i][23:8], exp_addr(i));
			chk_byte(ram_q[i][7:0], prog[i]);
		end
	endtask

	initial begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		$display("[FAIL] t=%0t watchdog expired", $time);
		close_out();
	end

	initial begin
		void'($urandom(98));
		run_case(1'b1, 1'b0, 1 + $urandom_range(3));
		run_case(1'b0, 1'b1, 0);
		run_case(1'b0, 1'b0, 2);
		run_case(1'b1, 1'b1, 0);
		@(negedge core_clk);
		watchdog_reset = 1'b1;
		@(negedge core_clk);
		watchdog_reset = 1'b0;
		host_inst.rx_q.delete();
		chk_flag(boot_mode, 1'b1);
		adjust();
		do_reset(1'b1, 1'b0);
		chk_flag(user_mode, 1'b1);
		chk_flag(boot_mode, 1'b0);
		close_out();
	end
endmodule // serial_boot_loader_tb
